/* File: sram_pkg.sv */
// Shared constants and types for the separate-port double-rate SRAM link.
package sram_pkg;

  // Geometry of the narrow configuration: two 18-bit words per address.
  localparam int DATA_W = 18;
  localparam int BYTE_W = 9;
  localparam int BYTES  = 2;
  localparam int ADDR_W = 19;
  localparam int BURST  = 2;

  // Controller phase counter: the link clock period is four system clocks.
  localparam logic [1:0] PH_K_RISE    = 2'h0;
  localparam logic [1:0] PH_LAUNCH_WR = 2'h1;
  localparam logic [1:0] PH_KN_RISE   = 2'h2;
  localparam logic [1:0] PH_LAUNCH_RD = 2'h3;

  // Read capture taps, in system clocks after the read address edge.
  localparam int PIPE_LEN    = 9;
  localparam int TAP_W0_FULL = 4;
  localparam int TAP_W1_FULL = 6;
  localparam int TAP_W0_HALF = 6;
  localparam int TAP_W1_HALF = 8;

  // Read data buffer in the controller.
  localparam logic [1:0] FIFO_DEPTH = 2'h2;

  typedef logic [DATA_W-1:0] word_t;
  typedef logic [BYTES-1:0]  byteen_t;
  typedef logic [ADDR_W-1:0] addr_t;

endpackage

/* File: sram_link_if.sv */
// Pin-level link between the memory controller and the SRAM device.
`timescale 1ns/10ps
interface sram_link_if;

  // Input clock pair and output clock pair, both made by the controller.
  logic                kClk;
  logic                kClkN;
  logic                cClk;
  logic                cClkN;
  // Shared address bus and port selects.
  sram_pkg::addr_t     addr;
  logic                readPortSelect_n;
  logic                writePortSelect_n;
  sram_pkg::byteen_t   byteWriteSelect_n;
  // Write data in, read data out.
  sram_pkg::word_t     d;
  sram_pkg::word_t     q;
  // Echo clocks that travel with the read data.
  logic                echoStrobe;
  logic                echoStrobeN;
  // Static latency mode strap.
  logic                pllBypassSelect;

  modport mem (
    input  kClk,
    input  kClkN,
    input  cClk,
    input  cClkN,
    input  addr,
    input  readPortSelect_n,
    input  writePortSelect_n,
    input  byteWriteSelect_n,
    input  d,
    input  pllBypassSelect,
    output q,
    output echoStrobe,
    output echoStrobeN
  );

  modport ctrl (
    output kClk,
    output kClkN,
    output cClk,
    output cClkN,
    output addr,
    output readPortSelect_n,
    output writePortSelect_n,
    output byteWriteSelect_n,
    output d,
    output pllBypassSelect,
    input  q,
    input  echoStrobe,
    input  echoStrobeN
  );

endinterface

/* File: sram_ddr_device.sv */
// SRAM device end: two-word burst array with separate double-rate read and write ports.
`timescale 1ns/10ps

// Contract
// - Read then write address share bus, alternate halves.
// - Each access moves exactly two words.
// - Two 18-bit words stored per address.
// - Data moves on both clocks of pair.
// - Bypass high gives 1.5 cycle read latency.
// - Bypass low gives one cycle read latency.
// - Read and write ports run independently, concurrently.
// - Separate read and write selects per port.
// - Inputs captured on input clock pair rises.
// - Read data launched from output clock pair.
// - Array write completes without further strobes.
// - Echo clocks travel aligned with read data.
// - Only rising edges of clock pair used.
// - Reads return most recently written data.
// - Write select low starts write, else ignored.
// - Byte selects store chosen bytes, others kept.
// - Read address on true rise, write on complement.
module sram_ddr_device (
  // Pins toward the controller.
  sram_link_if.mem            link,
  // Last address committed by the write port.
  output sram_pkg::addr_t     lastWriteAddr
);

  localparam int LANES = sram_pkg::BYTES;
  localparam int BW    = sram_pkg::BYTE_W;

  // Read port state, input clock domain.
  logic                rdPend_r;
  sram_pkg::addr_t     rdAddr_r;
  // Write port state, input clock domain.
  logic                wrPend_r;
  sram_pkg::word_t     wrWord0_r;
  sram_pkg::byteen_t   wrBe0_r;
  // Output pipeline, output clock domain.
  logic                stPend_r;
  sram_pkg::addr_t     stAddr_r;
  sram_pkg::word_t     qRise_r;
  sram_pkg::word_t     qFall_r;
  logic                modeMeta_r;
  logic                halfCycle_r;

  // Array read ports, one word per burst slot.
  sram_pkg::word_t     firstNow;
  sram_pkg::word_t     secondSt;
  sram_pkg::word_t     fallSt;

  wire [sram_pkg::ADDR_W:0] idxFirstNow = {rdAddr_r, 1'b0};
  wire [sram_pkg::ADDR_W:0] idxSecondSt = {stAddr_r, 1'b1};
  wire [sram_pkg::ADDR_W:0] idxFallSt   = {stAddr_r, ~halfCycle_r};
  wire [sram_pkg::ADDR_W:0] idxWr0      = {link.addr, 1'b0};
  wire [sram_pkg::ADDR_W:0] idxWr1      = {link.addr, 1'b1};

  // Read address and select on the true clock rise; falling edges are never used.
  always_ff @(posedge link.kClk) begin
    rdPend_r <= ~link.readPortSelect_n;
    if (!link.readPortSelect_n) begin
      rdAddr_r <= link.addr;
    end
  end

  // First write word, its byte selects and the write select on the true clock rise.
  always_ff @(posedge link.kClk) begin
    wrPend_r <= ~link.writePortSelect_n;
    if (!link.writePortSelect_n) begin
      wrWord0_r <= link.d;
      wrBe0_r   <= ~link.byteWriteSelect_n;
    end
  end

  always_ff @(posedge link.kClkN) begin
    if (wrPend_r) begin
      lastWriteAddr <= link.addr;
    end
  end

  // One memory per byte lane keeps each lane's write enable on its own.
  genvar lane;
  generate
    for (lane = 0; lane < LANES; lane++) begin : g_lane
      logic [BW-1:0] laneMem [0:(2 ** (sram_pkg::ADDR_W + 1)) - 1];

      // The write commits on the complement rise that brings the address and second word,
      // so no later strobe is needed and the port is free again for the next cycle.
      always_ff @(posedge link.kClkN) begin
        if (wrPend_r) begin
          if (wrBe0_r[lane]) begin
            laneMem[idxWr0] <= wrWord0_r[lane*BW +: BW];
          end
          if (!link.byteWriteSelect_n[lane]) begin
            laneMem[idxWr1] <= link.d[lane*BW +: BW];
          end
        end
      end

      assign firstNow[lane*BW +: BW] = laneMem[idxFirstNow];
      assign secondSt[lane*BW +: BW] = laneMem[idxSecondSt];
      assign fallSt[lane*BW +: BW]   = laneMem[idxFallSt];
    end
  endgenerate

  // The array is read at launch time, not at address time, so a write committed on the
  // complement rise of the same cycle is already visible and no bypass path is needed.
  always_ff @(posedge link.cClk) begin
    modeMeta_r  <= link.pllBypassSelect;
    halfCycle_r <= modeMeta_r;
    stPend_r    <= rdPend_r;
    stAddr_r    <= rdAddr_r;
    if (halfCycle_r) begin
      if (stPend_r) begin
        qRise_r <= secondSt;
      end
    end else if (rdPend_r) begin
      qRise_r <= firstNow;
    end
  end

  // Complement output rise: first word in the long mode, second word in the short one.
  always_ff @(posedge link.cClkN) begin
    if (stPend_r) begin
      qFall_r <= fallSt;
    end
  end

  // Double-rate output: each half period shows the word launched by the last rise.
  assign link.q = link.cClk ? qRise_r : qFall_r;

  // The echo pair is taken from the output clocks so it moves exactly with the data.
  assign link.echoStrobe  = link.cClk;
  assign link.echoStrobeN = link.cClkN;

endmodule

/* File: sram_ddr_controller.sv */
// Memory controller end: makes the link clocks, issues bursts and buffers read data.
`timescale 1ns/10ps
module sram_ddr_controller (
  // System clock and reset.
  input  logic                clk,
  input  logic                sys_rst,
  // Latency mode, high for the 1.5 cycle mode.
  input  logic                halfCycleMode,
  // Read requests.
  input  logic                rdReq,
  input  sram_pkg::addr_t     rdAddr,
  output logic                rdReady,
  // Write requests.
  input  logic                wrReq,
  input  sram_pkg::addr_t     wrAddr,
  input  sram_pkg::word_t     wrWord0,
  input  sram_pkg::word_t     wrWord1,
  input  sram_pkg::byteen_t   wrByteEn0,
  input  sram_pkg::byteen_t   wrByteEn1,
  output logic                wrReady,
  // Read data toward the user.
  output logic                rdValid,
  output sram_pkg::word_t     rdWord0,
  output sram_pkg::word_t     rdWord1,
  input  logic                rdTaken,
  // Pins toward the device.
  sram_link_if.ctrl           link
);

  logic [1:0]                      phase_r;
  logic                            kClk_r;
  logic                            modeSel_r;
  sram_pkg::addr_t                 addr_r;
  logic                            rpsN_r;
  logic                            wpsN_r;
  sram_pkg::byteen_t               bwsN_r;
  sram_pkg::word_t                 d_r;
  sram_pkg::addr_t                 wrAddrHold_r;
  sram_pkg::word_t                 wrWord1Hold_r;
  sram_pkg::byteen_t               wrBe1Hold_r;
  logic [sram_pkg::PIPE_LEN-1:0]   rdPipe_r;
  sram_pkg::word_t                 capWord0_r;
  logic [1:0]                      outstanding_r;
  logic [2*sram_pkg::DATA_W-1:0]   fifoMem_r [0:1];
  logic                            wrPtr_r;
  logic                            rdPtr_r;
  logic [1:0]                      count_r;

  wire       launchRd  = (phase_r == sram_pkg::PH_LAUNCH_RD);
  wire       launchWr2 = (phase_r == sram_pkg::PH_LAUNCH_WR);
  wire       kRise     = (phase_r == sram_pkg::PH_K_RISE);
  wire [2:0] inUse     = {1'b0, outstanding_r} + {1'b0, count_r};
  // A read is taken only when its burst is sure of a buffer slot, so a stalled
  // consumer throttles new reads instead of losing returned words.
  wire       rdAccept  = launchRd && rdReq && (inUse < {1'b0, sram_pkg::FIFO_DEPTH});
  wire       wrAccept  = launchRd && wrReq;
  wire       issueNow  = kRise && !rpsN_r;
  // Capture taps follow the latency the device was told to use.
  wire       cap0      = modeSel_r ? rdPipe_r[sram_pkg::TAP_W0_HALF] : rdPipe_r[sram_pkg::TAP_W0_FULL];
  wire       cap1      = modeSel_r ? rdPipe_r[sram_pkg::TAP_W1_HALF] : rdPipe_r[sram_pkg::TAP_W1_FULL];
  wire       pop       = rdValid && rdTaken;

  assign rdReady = rdAccept;
  assign wrReady = launchRd;
  assign rdValid = (count_r != 2'h0);
  assign rdWord0 = fifoMem_r[rdPtr_r][sram_pkg::DATA_W-1:0];
  assign rdWord1 = fifoMem_r[rdPtr_r][2*sram_pkg::DATA_W-1:sram_pkg::DATA_W];

  // Output clocks equal the input clocks, so the echo pair lines up with this capture.
  assign link.kClk              = kClk_r;
  assign link.kClkN             = ~kClk_r;
  assign link.cClk              = kClk_r;
  assign link.cClkN             = ~kClk_r;
  assign link.addr              = addr_r;
  assign link.readPortSelect_n  = rpsN_r;
  assign link.writePortSelect_n = wpsN_r;
  assign link.byteWriteSelect_n = bwsN_r;
  assign link.d                 = d_r;
  assign link.pllBypassSelect   = modeSel_r;

  // Link clock divider: one link period is four system clocks.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      phase_r <= 2'h0;
      kClk_r  <= 1'b0;
    end else begin
      phase_r <= phase_r + 2'h1;
      if (kRise) begin
        kClk_r <= 1'b1;
      end else if (phase_r == sram_pkg::PH_KN_RISE) begin
        kClk_r <= 1'b0;
      end
    end
  end

  // Mode changes only while the link is idle in reset, which keeps it static in use.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      modeSel_r <= halfCycleMode;
    end
  end

  // Pins change one system clock before the rise that samples them.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rpsN_r <= 1'b1;
      wpsN_r <= 1'b1;
      bwsN_r <= 2'h3;
      addr_r <= '0;
      d_r    <= '0;
    end else if (launchRd) begin
      rpsN_r <= ~rdAccept;
      wpsN_r <= ~wrAccept;
      if (rdAccept) begin
        addr_r <= rdAddr;
      end
      if (wrAccept) begin
        d_r    <= wrWord0;
        bwsN_r <= ~wrByteEn0;
      end
    end else if (launchWr2 && !wpsN_r) begin
      addr_r <= wrAddrHold_r;
      d_r    <= wrWord1Hold_r;
      bwsN_r <= ~wrBe1Hold_r;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wrAddrHold_r  <= '0;
      wrWord1Hold_r <= '0;
      wrBe1Hold_r   <= 2'h0;
    end else if (wrAccept) begin
      wrAddrHold_r  <= wrAddr;
      wrWord1Hold_r <= wrWord1;
      wrBe1Hold_r   <= wrByteEn1;
    end
  end

  // Read return: latency pipe, word pairing and the two-entry buffer.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdPipe_r      <= '0;
      capWord0_r    <= '0;
      outstanding_r <= 2'h0;
    end else begin
      rdPipe_r <= {rdPipe_r[sram_pkg::PIPE_LEN-2:0], issueNow};
      if (cap0) begin
        capWord0_r <= link.q;
      end
      outstanding_r <= outstanding_r + {1'b0, rdAccept} - {1'b0, cap1};
    end
  end

  always_ff @(posedge clk) begin
    if (cap1) begin
      fifoMem_r[wrPtr_r] <= {link.q, capWord0_r};
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wrPtr_r <= 1'b0;
      rdPtr_r <= 1'b0;
      count_r <= 2'h0;
    end else begin
      wrPtr_r <= wrPtr_r ^ cap1;
      rdPtr_r <= rdPtr_r ^ pop;
      count_r <= count_r + {1'b0, cap1} - {1'b0, pop};
    end
  end

endmodule

/* File: sram_link_checker.sv */
// Concurrent checks on the pin-level link between the controller and the device.
`timescale 1ns/10ps
module sram_link_checker (
  // System clock and reset.
  input logic              clk,
  input logic              sys_rst,
  // Clock pairs and echoes.
  input logic              kClk,
  input logic              kClkN,
  input logic              cClk,
  input logic              cClkN,
  input logic              echoStrobe,
  input logic              echoStrobeN,
  // Address, selects and data.
  input sram_pkg::addr_t   addr,
  input logic              readPortSelect_n,
  input logic              writePortSelect_n,
  input sram_pkg::byteen_t byteWriteSelect_n,
  input sram_pkg::word_t   d,
  input sram_pkg::word_t   q,
  input logic              pllBypassSelect
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_kclk_pair: assert property (kClkN == ~kClk)
    else $error("input clock pair not complementary");
  a_out_pair: assert property (cClk == kClk && cClkN == kClkN)
    else $error("output clock pair off the input pair");
  a_echo_aligned: assert property (echoStrobe == cClk && echoStrobeN == cClkN)
    else $error("echo clocks not aligned with output clocks");
  a_kclk_period: assert property ($rose(kClk) |-> ##1 kClk ##1 !kClk [*2] ##1 kClk)
    else $error("input clock period is not four cycles");
  a_q_launch: assert property ($changed(q) |-> $changed(cClk))
    else $error("read data moved away from an output clock edge");
  a_bypass_static: assert property ($stable(pllBypassSelect))
    else $error("latency strap changed during operation");
  a_sel_setup: assert property (($changed(readPortSelect_n) || $changed(writePortSelect_n))
    |-> $stable(kClk) && !kClk)
    else $error("port select moved at an input clock edge");
  a_addr_setup: assert property ($changed(addr) |-> $stable(kClk) && $stable(kClkN))
    else $error("address moved at an input clock edge");
  a_data_setup: assert property (($changed(d) || $changed(byteWriteSelect_n))
    |-> $stable(kClk) && $stable(kClkN))
    else $error("write data moved at an input clock edge");

  c_read: cover property ($rose(kClk) && !readPortSelect_n);
  c_write: cover property ($rose(kClk) && !writePortSelect_n);
  c_both: cover property ($rose(kClk) && !readPortSelect_n && !writePortSelect_n);
  c_half: cover property (pllBypassSelect && !readPortSelect_n);
endmodule

/* File: tb.sv */
// Self-checking bench joining the controller and device ends of the SRAM link.
`timescale 1ns/10ps
module tb;
  logic              clk = 1'b0;
  logic              sys_rst = 1'b1;
  logic              halfCycleMode;
  logic              rdReq;
  sram_pkg::addr_t   rdAddr;
  logic              rdReady;
  logic              wrReq;
  sram_pkg::addr_t   wrAddr;
  sram_pkg::word_t   wrWord0;
  sram_pkg::word_t   wrWord1;
  sram_pkg::byteen_t wrByteEn0;
  sram_pkg::byteen_t wrByteEn1;
  logic              wrReady;
  logic              rdValid;
  sram_pkg::word_t   rdWord0;
  sram_pkg::word_t   rdWord1;
  logic              rdTaken = 1'b0;
  sram_pkg::addr_t   lastWriteAddr;
  logic              stall = 1'b0;
  integer            seed = 32'h9D22FA7E;
  int                errors = 0;
  int                tests_run = 0;
  sram_pkg::word_t   mem [bit [19:0]];
  logic [35:0]       expQ [$];

  sram_link_if sram_link_if_i ();
  sram_ddr_controller sram_ddr_controller_i (.clk(clk), .sys_rst(sys_rst), .halfCycleMode(halfCycleMode),
    .rdReq(rdReq), .rdAddr(rdAddr), .rdReady(rdReady), .wrReq(wrReq), .wrAddr(wrAddr), .wrWord0(wrWord0),
    .wrWord1(wrWord1), .wrByteEn0(wrByteEn0), .wrByteEn1(wrByteEn1), .wrReady(wrReady), .rdValid(rdValid),
    .rdWord0(rdWord0), .rdWord1(rdWord1), .rdTaken(rdTaken), .link(sram_link_if_i.ctrl));
  sram_ddr_device sram_ddr_device_i (.link(sram_link_if_i.mem), .lastWriteAddr(lastWriteAddr));
  sram_link_checker sram_link_checker_i (.clk(clk), .sys_rst(sys_rst), .kClk(sram_link_if_i.kClk),
    .kClkN(sram_link_if_i.kClkN), .cClk(sram_link_if_i.cClk), .cClkN(sram_link_if_i.cClkN),
    .echoStrobe(sram_link_if_i.echoStrobe), .echoStrobeN(sram_link_if_i.echoStrobeN),
    .addr(sram_link_if_i.addr), .readPortSelect_n(sram_link_if_i.readPortSelect_n),
    .writePortSelect_n(sram_link_if_i.writePortSelect_n), .byteWriteSelect_n(sram_link_if_i.byteWriteSelect_n),
    .d(sram_link_if_i.d), .q(sram_link_if_i.q), .pllBypassSelect(sram_link_if_i.pllBypassSelect));

  always #5 clk = ~clk;
  // Random stalls by the reader exercise the two-entry buffer.
  always @(posedge clk) rdTaken <= #1 !stall && ($random(seed) % 3 != 0);

  task automatic close_out(input bit hung);
    if (hung) errors++;
    if (errors == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [35:0] e, input logic [35:0] g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  function automatic sram_pkg::word_t rw();
    return sram_pkg::word_t'($random(seed));
  endfunction

  function automatic sram_pkg::addr_t adr(input int i);
    return (i == 7) ? 19'h7FFFF : sram_pkg::addr_t'(i * 37);
  endfunction

  task automatic upd(input sram_pkg::addr_t a, input bit i, input sram_pkg::word_t w, input sram_pkg::byteen_t be);
    for (int b = 0; b < sram_pkg::BYTES; b++)
      if (be[b]) mem[{a, i}][b*sram_pkg::BYTE_W +: sram_pkg::BYTE_W] = w[b*sram_pkg::BYTE_W +: sram_pkg::BYTE_W];
  endtask

  // Requests stay up until the next call, so back-to-back periods need no gap.
  task automatic op(input bit rd, input sram_pkg::addr_t ra, input bit wr, input sram_pkg::addr_t wa,
                    input sram_pkg::word_t w0, input sram_pkg::word_t w1, input sram_pkg::byteen_t b0,
                    input sram_pkg::byteen_t b1);
    int n;
    rdReq = rd;
    rdAddr = ra;
    wrReq = wr;
    wrAddr = wa;
    wrWord0 = w0;
    wrWord1 = w1;
    wrByteEn0 = b0;
    wrByteEn1 = b1;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (!((!rd || rdReady === 1'b1) && (!wr || wrReady === 1'b1)) && n < 300);
    if (n >= 300) close_out(1'b1);
    @(posedge clk);
    if (wr) upd(wa, 1'b0, w0, b0);
    if (wr) upd(wa, 1'b1, w1, b1);
    if (rd) expQ.push_back({mem[{ra, 1'b0}], mem[{ra, 1'b1}]});
    #1;
  endtask

  task automatic rest();
    rdReq = 1'b0;
    wrReq = 1'b0;
  endtask

  task automatic drain();
    int n;
    n = 0;
    while ((expQ.size() != 0 || rdValid !== 1'b0) && n < 500) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 500) close_out(1'b1);
  endtask

  always @(posedge clk) begin
    if (!sys_rst && rdValid === 1'b1 && rdTaken === 1'b1) begin
      if (expQ.size() == 0) chk("rdWord", 36'hX, {rdWord0, rdWord1});
      else chk("rdWord", expQ.pop_front(), {rdWord0, rdWord1});
    end
  end

  initial begin
    int n;
    logic hold;
    halfCycleMode = 1'b0;
    rest();
    rdAddr = 19'h0;
    wrAddr = 19'h0;
    wrWord0 = 18'h0;
    wrWord1 = 18'h0;
    wrByteEn0 = 2'h0;
    wrByteEn1 = 2'h0;
    // The second pass resets in mid-run; the array keeps its contents.
    for (int m = 0; m < 2; m++) begin
      @(posedge clk);
      #1;
      sys_rst = 1'b1;
      halfCycleMode = m[0];
      repeat (20) @(posedge clk);
      #1;
      sys_rst = 1'b0;
      for (int i = 0; i < 8; i++) op(0, 0, 1, adr(i), rw(), rw(), 2'h3, 2'h3);
      rest();
      repeat (4) @(negedge clk);
      chk("lastWriteAddr", 36'(19'h7FFFF), 36'(lastWriteAddr));
      @(posedge clk);
      #1;
      for (int i = 0; i < 8; i++) op(1, adr(7 - i), 0, 0, 0, 0, 0, 0);
      rest();
      drain();
      // A spacer read keeps each new write clear of the previous read's launch.
      for (int b = 0; b < 4; b++) begin
        op(1, adr(1), 1, adr(1), rw(), rw(), 2'(b), 2'(3 - b));
        op(1, adr(5), 0, 0, 0, 0, 0, 0);
      end
      op(1, adr(2), 1, adr(3), rw(), rw(), 2'h3, 2'h1);
      rest();
      drain();
      op(1, adr(4), 0, 0, 0, 0, 0, 0);
      rest();
      n = 0;
      do begin
        @(negedge clk);
        n++;
      end while (rdValid !== 1'b1 && n < 40);
      if (n >= 40) close_out(1'b1);
      chk("readLatency", 36'(m ? 11 : 9), 36'(n));
      drain();
      stall = 1'b1;
      op(1, adr(5), 0, 0, 0, 0, 0, 0);
      op(1, adr(6), 0, 0, 0, 0, 0, 0);
      hold = 1'b0;
      repeat (24) begin
        @(negedge clk);
        hold = hold | rdReady;
      end
      chk("rdReady", 36'h0, 36'(hold));
      @(posedge clk);
      #1;
      rest();
      stall = 1'b0;
      drain();
    end
    close_out(1'b0);
  end
endmodule
